// File: serial_map.vh
`ifndef SERIAL_MAP_VH
`define SERIAL_MAP_VH
// register byte offsets
`define OFS_MODE 8'h00
`define OFS_BITRATE 8'h04
`define OFS_CONTROL 8'h08
`define OFS_TXDATA 8'h0C
`define OFS_STATUS 8'h10
`define OFS_RXDATA 8'h14
// mode register fields
`define MODE_CKS_LO 0
`define MODE_CKS_HI 1
`define MODE_MP 2
`define MODE_STOP 3
`define MODE_ODD 4
`define MODE_PE 5
`define MODE_CHR 6
// control register fields
`define CTL_CLOCK_SOURCE_LO 0
`define CTL_CLOCK_SOURCE_HI 1
`define CTL_TX_END_IRQ_ENABLE 2
`define CTL_MULTIPROC_IRQ_ENABLE 3
`define CTL_RE 4
`define CTL_TE 5
`define CTL_RIE 6
`define CTL_TIE 7
// status register fields
`define ST_MPBT 0
`define ST_MPB 1
`define ST_TX_END_FLAG 2
`define ST_PER 3
`define ST_FER 4
`define ST_OVERRUN_FLAG 5
`define ST_RX_FULL_FLAG 6
`define ST_TX_BUFFER_EMPTY_FLAG 7
// reset values
`define MODE_RST 8'h00
`define BITRATE_RST 8'hFF
`define CONTROL_RST 8'h00
`define STATUS_RST 8'h84
// htrans
`define HTRANS_NONSEQ 2'b10
// oversampling
`define OVERSAMPLE 16
`define SAMPLE_POINT 4'h7
`define LAST_TICK 4'hF
`define HALF_TICK 4'h8
`endif

// File: async_serial_uart.v
`timescale 1ns/10ps
`include "serial_map.vh"
// Overview of operation
// - external clock pin runs at sixteen times the bit rate
// - internal clock output toggles at bit rate, rising edge mid-bit
// - clock output starts as soon as control write selects it
// - clearing transmit enable sets buffer empty flag and resets shifter
// - clearing receive enable keeps receive flags and data untouched
// - enabled transmitter idles mark, enabled receiver waits for start
// - cleared empty flag loads shifter, sets flag, starts frame, requests
// - frame is start, data LSB first, optional parity/mp, stop bits
// - seven bits when char length set; parity only outside mp format
// - stop-length bit selects two stop bits
// - line stays high between frames
// - at stop bit load next data or set end flag and request
// - dma write of transmit data clears empty flag automatically
// - receiver syncs on start and shifts data LSB first
// - parity checked; only first stop bit must be high
// - good frame with empty buffer stores data and sets full flag
// - frame ending while full sets overrun, data not stored
// - framing or parity error sets flag and still stores data
// - any error flag blocks reception and requests error interrupt
// - start falling edge syncs; sample at eighth sixteenth of bit
module async_serial_uart (
  // clock and reset
  input wire ref_clk,
  input wire reset_n,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // dma handshakes
  input wire dma_tx_write,
  input wire dma_rx_read,
  // serial pins
  input wire rxd,
  output reg txd,
  input wire sck_in,
  output reg sck_out,
  output reg sck_oe,
  // interrupt requests
  output reg tx_empty_irq,
  output reg tx_end_irq,
  output reg rx_full_irq,
  output reg rx_error_irq
);
  reg rst_meta, rst_sync_n;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end
  reg [7:0] serial_mode_reg, bit_rate_reg, serial_control_reg, tx_data_reg, rx_data_reg;
  reg [7:0] tx_shift_reg, rx_shift_reg;
  reg tx_buffer_empty_flag, tx_end_flag, rx_full_flag;
  reg overrun_flag, framing_error_flag, parity_error_flag;
  reg multiproc_bit, multiproc_bit_tx;
  wire char_length_bit = serial_mode_reg[`MODE_CHR];
  wire parity_enable = serial_mode_reg[`MODE_PE];
  wire multiproc_format_bit = serial_mode_reg[`MODE_MP];
  wire two_stop = serial_mode_reg[`MODE_STOP];
  wire odd_parity = serial_mode_reg[`MODE_ODD];
  wire clock_source_hi = serial_control_reg[`CTL_CLOCK_SOURCE_HI];
  wire clock_source_lo = serial_control_reg[`CTL_CLOCK_SOURCE_LO];
  wire tx_enable = serial_control_reg[`CTL_TE];
  wire rx_enable = serial_control_reg[`CTL_RE];
  wire any_err = overrun_flag | framing_error_flag | parity_error_flag;
  wire [7:0] status_word = {tx_buffer_empty_flag, rx_full_flag, overrun_flag,
    framing_error_flag, parity_error_flag, tx_end_flag, multiproc_bit, multiproc_bit_tx};
  // ahb-lite: latch address phase, act in data phase, zero wait states
  reg ph_wr, ph_rd;
  reg [7:0] ph_addr;
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (hready) begin
      ph_wr <= hsel & (htrans == `HTRANS_NONSEQ) & hwrite;
      ph_rd <= hsel & (htrans == `HTRANS_NONSEQ) & ~hwrite;
      ph_addr <= haddr;
    end
  end
  wire wr_mode = ph_wr & (ph_addr == `OFS_MODE);
  wire wr_ctl = ph_wr & (ph_addr == `OFS_CONTROL);
  wire wr_stat = ph_wr & (ph_addr == `OFS_STATUS);
  wire wr_tdr = ph_wr & (ph_addr == `OFS_TXDATA);
  wire rd_next = hready & hsel & (htrans == `HTRANS_NONSEQ) & ~hwrite;
  // read data registered at the address phase so it stands in the data phase
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_next) begin
      case (haddr)
        `OFS_MODE: hrdata <= {24'h00_0000, serial_mode_reg};
        `OFS_BITRATE: hrdata <= {24'h00_0000, bit_rate_reg};
        `OFS_CONTROL: hrdata <= {24'h00_0000, serial_control_reg};
        `OFS_TXDATA: hrdata <= {24'h00_0000, tx_data_reg};
        `OFS_STATUS: hrdata <= {24'h00_0000, status_word};
        `OFS_RXDATA: hrdata <= {24'h00_0000, rx_data_reg};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end
  // bit-rate generator: 16x tick from divider or external clock
  reg [7:0] div_cnt;
  reg sck_d1;
  reg tick;
  wire use_ext = clock_source_hi;
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_cnt <= 8'h00;
      sck_d1 <= 1'b0;
      tick <= 1'b0;
    end else begin
      sck_d1 <= sck_in;
      if (use_ext) begin
        tick <= sck_in & ~sck_d1;
        div_cnt <= 8'h00;
      end else if (div_cnt >= bit_rate_reg) begin
        tick <= 1'b1;
        div_cnt <= 8'h00;
      end else begin
        tick <= 1'b0;
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end
  // transmitter
  localparam TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100;
  localparam TX_PAR = 5'b01000, TX_STOP = 5'b10000;
  reg [4:0] tx_state;
  reg [3:0] tx_sub;
  reg [2:0] tx_bit;
  reg tx_par_acc, tx_mpb, tx_stop2;
  wire tx_bit_end = tick & (tx_sub == `LAST_TICK);
  wire [2:0] last_data = char_length_bit ? 3'd6 : 3'd7;
  wire extra_bit = multiproc_format_bit | parity_enable;
  wire tx_buffer_empty_flag_clear_req = wr_stat & ~hwdata[`ST_TX_BUFFER_EMPTY_FLAG] & tx_buffer_empty_flag;
  wire tx_buffer_empty_flag_set_evt = (tx_state == TX_IDLE) & tx_enable & ~tx_buffer_empty_flag & tick;
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_state <= TX_IDLE;
      tx_sub <= 4'h0;
      tx_bit <= 3'd0;
      tx_shift_reg <= 8'h00;
      tx_par_acc <= 1'b0;
      tx_mpb <= 1'b0;
      tx_stop2 <= 1'b0;
      txd <= 1'b1;
      tx_end_flag <= 1'b1;
      tx_buffer_empty_flag <= 1'b1;
      tx_empty_irq <= 1'b0;
      tx_end_irq <= 1'b0;
    end else begin
      if (!tx_enable) begin
        tx_state <= TX_IDLE;
        tx_shift_reg <= 8'h00;
        tx_buffer_empty_flag <= 1'b1;
        txd <= 1'b1;
        tx_sub <= 4'h0;
      end else begin
        if (tx_buffer_empty_flag_clear_req | (dma_tx_write & tx_buffer_empty_flag))
          tx_buffer_empty_flag <= 1'b0;
        if (wr_stat & ~hwdata[`ST_TX_END_FLAG])
          tx_end_flag <= 1'b0;
        if (tick && tx_state != TX_IDLE)
          tx_sub <= tx_sub + 4'h1;
        case (tx_state)
          TX_IDLE: begin
            txd <= 1'b1;
            if (tx_buffer_empty_flag_set_evt) begin
              tx_shift_reg <= tx_data_reg;
              tx_mpb <= multiproc_bit_tx;
              tx_buffer_empty_flag <= 1'b1;
              tx_end_flag <= 1'b0;
              tx_sub <= 4'h0;
              txd <= 1'b0;
              tx_state <= TX_START;
            end
          end
          TX_START: if (tx_bit_end) begin
            txd <= tx_shift_reg[0];
            tx_par_acc <= tx_shift_reg[0];
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            tx_bit <= 3'd0;
            tx_state <= TX_DATA;
          end
          TX_DATA: if (tx_bit_end) begin
            if (tx_bit == last_data) begin
              if (extra_bit) begin
                txd <= multiproc_format_bit ? tx_mpb : (tx_par_acc ^ odd_parity);
                tx_state <= TX_PAR;
              end else begin
                txd <= 1'b1;
                tx_stop2 <= two_stop;
                tx_state <= TX_STOP;
              end
            end else begin
              txd <= tx_shift_reg[0];
              tx_par_acc <= tx_par_acc ^ tx_shift_reg[0];
              tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
              tx_bit <= tx_bit + 3'd1;
            end
          end
          TX_PAR: if (tx_bit_end) begin
            txd <= 1'b1;
            tx_stop2 <= two_stop;
            tx_state <= TX_STOP;
          end
          TX_STOP: if (tx_bit_end) begin
            if (tx_stop2) begin
              tx_stop2 <= 1'b0;
            end else if (!tx_buffer_empty_flag) begin
              tx_shift_reg <= tx_data_reg;
              tx_mpb <= multiproc_bit_tx;
              tx_buffer_empty_flag <= 1'b1;
              txd <= 1'b0;
              tx_state <= TX_START;
            end else begin
              tx_end_flag <= 1'b1;
              tx_state <= TX_IDLE;
            end
          end
          default: tx_state <= TX_IDLE;
        endcase
      end
      tx_empty_irq <= tx_buffer_empty_flag & tx_enable & serial_control_reg[`CTL_TIE];
      tx_end_irq <= tx_end_flag & serial_control_reg[`CTL_TX_END_IRQ_ENABLE];
    end
  end
  // receiver
  localparam RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100, RX_TAIL = 4'b1000;
  reg [3:0] rx_state;
  reg [3:0] rx_sub;
  reg [2:0] rx_bit;
  reg rx_m, rx_s, rx_prev;
  reg rx_par_acc, rx_par_bad, rx_in_par, rx_mpb;
  wire rx_sample = tick & (rx_sub == `SAMPLE_POINT);
  wire rx_full_flag_clear = (wr_stat & ~hwdata[`ST_RX_FULL_FLAG]) | dma_rx_read;
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_m <= 1'b1;
      rx_s <= 1'b1;
      rx_prev <= 1'b1;
      rx_state <= RX_IDLE;
      rx_sub <= 4'h0;
      rx_bit <= 3'd0;
      rx_shift_reg <= 8'h00;
      rx_par_acc <= 1'b0;
      rx_par_bad <= 1'b0;
      rx_in_par <= 1'b0;
      rx_mpb <= 1'b0;
      rx_data_reg <= 8'h00;
      rx_full_flag <= 1'b0;
      overrun_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      multiproc_bit <= 1'b0;
      rx_full_irq <= 1'b0;
      rx_error_irq <= 1'b0;
    end else begin
      rx_m <= rxd;
      rx_s <= rx_m;
      if (tick)
        rx_prev <= rx_s;
      // software clears first; hardware sets below win
      if (rx_full_flag_clear)
        rx_full_flag <= 1'b0;
      if (wr_stat & ~hwdata[`ST_OVERRUN_FLAG])
        overrun_flag <= 1'b0;
      if (wr_stat & ~hwdata[`ST_FER])
        framing_error_flag <= 1'b0;
      if (wr_stat & ~hwdata[`ST_PER])
        parity_error_flag <= 1'b0;
      if (!rx_enable || any_err) begin
        rx_state <= RX_IDLE;
      end else begin
        if (tick)
          rx_sub <= rx_sub + 4'h1;
        case (rx_state)
          RX_IDLE: if (tick & rx_prev & ~rx_s) begin
            rx_sub <= 4'h1;
            rx_state <= RX_START;
          end
          RX_START: if (rx_sample) begin
            if (rx_s) begin
              rx_state <= RX_IDLE;
            end else begin
              rx_bit <= 3'd0;
              rx_par_acc <= 1'b0;
              rx_in_par <= 1'b0;
              rx_state <= RX_DATA;
            end
          end
          RX_DATA: if (rx_sample) begin
            rx_shift_reg <= char_length_bit ? {1'b0, rx_s, rx_shift_reg[6:1]}
              : {rx_s, rx_shift_reg[7:1]};
            rx_par_acc <= rx_par_acc ^ rx_s;
            if (rx_bit == last_data) begin
              rx_in_par <= extra_bit;
              rx_state <= RX_TAIL;
            end else begin
              rx_bit <= rx_bit + 3'd1;
            end
          end
          RX_TAIL: if (rx_sample) begin
            if (rx_in_par) begin
              rx_in_par <= 1'b0;
              rx_mpb <= rx_s;
              rx_par_bad <= ~multiproc_format_bit & (rx_par_acc ^ rx_s ^ odd_parity);
            end else begin
              rx_state <= RX_IDLE;
              if (rx_full_flag & ~rx_full_flag_clear) begin
                overrun_flag <= 1'b1;
              end else begin
                rx_data_reg <= rx_shift_reg;
                multiproc_bit <= rx_mpb;
                if (~rx_s)
                  framing_error_flag <= 1'b1;
                if (rx_par_bad)
                  parity_error_flag <= 1'b1;
                if (rx_s & ~rx_par_bad)
                  rx_full_flag <= 1'b1;
              end
              rx_par_bad <= 1'b0;
            end
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
      rx_full_irq <= rx_full_flag & serial_control_reg[`CTL_RIE];
      rx_error_irq <= any_err & serial_control_reg[`CTL_RIE];
    end
  end
  // registers written by software
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      serial_mode_reg <= `MODE_RST;
      bit_rate_reg <= `BITRATE_RST;
      serial_control_reg <= `CONTROL_RST;
      tx_data_reg <= 8'h00;
      multiproc_bit_tx <= 1'b0;
    end else begin
      if (wr_mode)
        serial_mode_reg <= hwdata[7:0];
      if (ph_wr & (ph_addr == `OFS_BITRATE))
        bit_rate_reg <= hwdata[7:0];
      if (wr_ctl)
        serial_control_reg <= hwdata[7:0];
      if (wr_tdr)
        tx_data_reg <= hwdata[7:0];
      if (wr_stat)
        multiproc_bit_tx <= hwdata[`ST_MPBT];
    end
  end
  // clock output: low first half of bit, rising edge at bit centre
  reg [3:0] ck_sub;
  wire [3:0] next_ck_sub = ck_sub + 4'h1;
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ck_sub <= 4'h0;
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
    end else begin
      sck_oe <= ~clock_source_hi & clock_source_lo;
      if (tx_buffer_empty_flag_set_evt) begin
        ck_sub <= 4'h0;
        sck_out <= 1'b0;
      end else if (tick) begin
        ck_sub <= next_ck_sub;
        sck_out <= (next_ck_sub >= `HALF_TICK);
      end
    end
  end
endmodule

// File: async_serial_uart_chk.sv
`timescale 1ns/10ps
`include "serial_map.vh"
module async_serial_uart_chk (
  // clock and reset
  input wire ref_clk,
  input wire reset_n,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // dma handshakes
  input wire dma_tx_write,
  input wire dma_rx_read,
  // serial pins
  input wire rxd,
  input wire txd,
  input wire sck_in,
  input wire sck_out,
  input wire sck_oe,
  // interrupt requests
  input wire tx_empty_irq,
  input wire tx_end_irq,
  input wire rx_full_irq,
  input wire rx_error_irq
);
  // shadow of the control register, taken at the end of each write data phase
  reg wr_pend;
  reg [7:0] wr_addr;
  reg [7:0] ctl;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      ctl <= 8'h00;
    end else begin
      if (wr_pend && wr_addr == `OFS_CONTROL) begin
        ctl <= hwdata[7:0];
      end
      wr_pend <= hsel && hready && htrans == `HTRANS_NONSEQ && hwrite;
      wr_addr <= haddr;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // every bit lasts at least sixteen ticks, so no txd level may end within eight cycles
  sequence s_start;
    $fell(txd);
  endsequence
  sequence s_mark;
    $rose(txd);
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_start_hold: assert property (s_start |-> !txd [*8])
    else $error("low level on txd ended too early");
  a_mark_hold: assert property (s_mark |-> txd [*8])
    else $error("high level on txd ended too early");
  a_clkout_on: assert property ((ctl[1:0] == 2'b01) [*3] |-> sck_oe)
    else $error("clock output not driven");
  a_clkout_off: assert property ((ctl[1:0] != 2'b01) [*3] |-> !sck_oe)
    else $error("clock pin driven outside clock output mode");
  a_txe_irq: assert property ((!ctl[`CTL_TIE]) [*3] |-> !tx_empty_irq)
    else $error("empty request while disabled");
  a_tx_end_flag_irq: assert property ((!ctl[`CTL_TX_END_IRQ_ENABLE]) [*3] |-> !tx_end_irq)
    else $error("end request while disabled");
  a_rxf_irq: assert property ((!ctl[`CTL_RIE]) [*3] |-> !rx_full_irq)
    else $error("full request while disabled");
  a_rxerr_irq: assert property ((!ctl[`CTL_RIE]) [*3] |-> !rx_error_irq)
    else $error("error request while disabled");
endmodule
bind async_serial_uart async_serial_uart_chk u_chk (.*);

// File: serial_node.sv
`timescale 1ns/10ps
module serial_node (
  // clock
  input wire ref_clk,
  // serial lines
  output logic rxd,
  input wire txd
);
  int bit_cyc = 16;
  int cyc = 0;
  initial rxd = 1'b1;
  always @(posedge ref_clk) cyc <= cyc + 1;
  // start bit, then n bits lsb first, then back to mark
  task send(input logic [11:0] v, input int n);
    @(posedge ref_clk);
    rxd <= 1'b0;
    for (int k = 0; k <= n; k++) begin
      repeat (bit_cyc) @(posedge ref_clk);
      rxd <= (k < n) ? v[k] : 1'b1;
    end
  endtask
  // samples mid-bit; t is the cycle count half a bit after the start edge
  task capture(input int n, output logic [11:0] f, output int t);
    f = 12'hFFF;
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge ref_clk);
    t = cyc;
    for (int k = 0; k < n; k++) begin
      repeat (bit_cyc) @(posedge ref_clk);
      f[k] = txd;
    end
  endtask
endmodule

// File: async_serial_uart_bench.sv
`timescale 1ns/10ps
`include "serial_map.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module async_serial_uart_bench;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, dma_tx_write = 1'b0, dma_rx_read = 1'b0;
  logic sck_in = 1'b0, ext = 1'b0, pv;
  logic [7:0] haddr = 8'h00, md, d1, d2, d3;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
  logic hready, hreadyout, hresp, rxd, txd, sck_out, sck_oe;
  logic tx_empty_irq, tx_end_irq, rx_full_irq, rx_error_irq;
  logic [11:0] f1, f2, ef;
  int num_errors = 0, n_compared = 0, n, sc, t1, t2;
  assign hready = hreadyout;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (ext) sck_in <= ~sck_in;
  async_serial_uart u_async_serial_uart (.*);
  serial_node u_serial_node (.*);
  task bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= `HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, v};
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    bus(1'b1, a, v);
  endtask
  task rdchk(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(nm, {24'h00_0000, e}, rd & {24'hFF_FFFF, m})
  endtask
  task setup(input logic [7:0] m, input logic [7:0] c);
    wr(`OFS_CONTROL, 8'h00);
    wr(`OFS_MODE, m);
    wr(`OFS_BITRATE, 8'h00);
    wr(`OFS_CONTROL, c & 8'h03);
    repeat (64) @(posedge ref_clk);
    wr(`OFS_CONTROL, c);
  endtask
  // bits after the start bit, lsb first; n counts them up to the last stop bit
  function automatic logic [11:0] frame(input logic [7:0] m, input logic [7:0] d,
      input logic pf, input logic sf, output int n);
    logic [11:0] v;
    v = 12'hFFF;
    n = 0;
    if (m[`MODE_CHR]) d[7] = 1'b0;
    for (int k = 0; k < 8 - m[`MODE_CHR]; k++) begin
      v[n] = d[k];
      n++;
    end
    if (m[`MODE_MP]) begin
      v[n] = 1'b0;
      n++;
    end else if (m[`MODE_PE]) begin
      v[n] = ^d ^ m[`MODE_ODD] ^ pf;
      n++;
    end
    v[n] = ~sf;
    n = n + 1 + m[`MODE_STOP];
    return v;
  endfunction
  function automatic logic [7:0] chars(input logic [7:0] m, input logic [7:0] d);
    return m[`MODE_CHR] ? {1'b0, d[6:0]} : d;
  endfunction
  task rx_frame(input logic [7:0] d, input logic pf, input logic sf);
    ef = frame(8'h20, d, pf, sf, n);
    u_serial_node.send(ef, n);
    repeat (4) @(posedge ref_clk);
  endtask
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200_000;
    num_errors++;
    conclude();
  end
  initial begin
    void'($urandom(36));
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rdchk("status", `OFS_STATUS, 8'hFF, `STATUS_RST);
    rdchk("bitrate", `OFS_BITRATE, 8'hFF, `BITRATE_RST);
    rdchk("unmapped", 8'h3C, 8'hFF, 8'h00);
    $display("register test done");
    for (int i = 0; i < 16; i++) begin
      md = {1'b0, i[3], i[2], 1'($urandom), i[1], i[0], 2'b00};
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      d3 = 8'($urandom);
      setup(md, 8'h74);
      ef = frame(md, d3, 1'b0, 1'b0, n);
      fork
        begin
          u_serial_node.capture(n, f1, t1);
          u_serial_node.capture(n, f2, t2);
        end
        u_serial_node.send(ef, n);
        begin
          wr(`OFS_TXDATA, d1);
          wr(`OFS_STATUS, 8'h7E);
          sc = 0;
          do begin
            bus(1'b0, `OFS_STATUS, 8'h00);
            sc++;
          end while (rd[`ST_TX_BUFFER_EMPTY_FLAG] !== 1'b1 && sc < 50);
          wr(`OFS_TXDATA, d2);
          dma_tx_write <= 1'b1;
          @(posedge ref_clk);
          dma_tx_write <= 1'b0;
        end
      join
      `CHK("frame1", frame(md, d1, 1'b0, 1'b0, n), f1)
      `CHK("frame2", frame(md, d2, 1'b0, 1'b0, n), f2)
      `CHK("gap", (n + 1) * 16, t2 - t1)
      repeat (20) @(posedge ref_clk);
      rdchk("status", `OFS_STATUS, 8'hC4, 8'hC4);
      `CHK("irqs", 2'b11, {tx_end_irq, rx_full_irq})
      rdchk("rxdata", `OFS_RXDATA, 8'hFF, chars(md, d3));
      dma_rx_read <= 1'b1;
      @(posedge ref_clk);
      dma_rx_read <= 1'b0;
      rdchk("rxfull", `OFS_STATUS, 8'h40, 8'h00);
      $display("format %0d done", i);
    end
    setup(8'h20, 8'h70);
    rx_frame(d1, 1'b1, 1'b0);
    rx_frame(d2, 1'b0, 1'b0);
    rdchk("perr", `OFS_STATUS, 8'h78, 8'h08);
    `CHK("erirq", 1'b1, rx_error_irq)
    rdchk("rxdata", `OFS_RXDATA, 8'hFF, d1);
    wr(`OFS_STATUS, 8'h87);
    rx_frame(d2, 1'b0, 1'b1);
    rdchk("ferr", `OFS_STATUS, 8'h78, 8'h10);
    rdchk("rxdata", `OFS_RXDATA, 8'hFF, d2);
    wr(`OFS_STATUS, 8'h87);
    rx_frame(d3, 1'b0, 1'b0);
    rx_frame(d2, 1'b0, 1'b0);
    rdchk("overrun", `OFS_STATUS, 8'h78, 8'h60);
    wr(`OFS_CONTROL, 8'h40);
    rdchk("hold", `OFS_STATUS, 8'h78, 8'h60);
    rdchk("rxdata", `OFS_RXDATA, 8'hFF, d3);
    $display("receive error test done");
    setup(8'h00, 8'hB0);
    wr(`OFS_TXDATA, 8'h00);
    wr(`OFS_STATUS, 8'h7E);
    repeat (100) @(posedge ref_clk);
    `CHK("midframe", 1'b0, txd)
    `CHK("txirq", 1'b1, tx_empty_irq)
    wr(`OFS_CONTROL, 8'h10);
    repeat (2) @(posedge ref_clk);
    `CHK("txidle", 1'b1, txd)
    rdchk("empty", `OFS_STATUS, 8'h80, 8'h80);
    wr(`OFS_BITRATE, 8'h01);
    wr(`OFS_CONTROL, 8'h01);
    repeat (4) @(posedge ref_clk);
    `CHK("clkoe", 1'b1, sck_oe)
    sc = 0;
    pv = sck_out;
    repeat (320) begin
      @(posedge ref_clk);
      sc += int'(sck_out && !pv);
      pv = sck_out;
    end
    `CHK("clkrises", 10, sc)
    $display("transmit stop and clock test done");
    ext <= 1'b1;
    setup(8'h00, 8'h22);
    u_serial_node.bit_cyc = 32;
    fork
      u_serial_node.capture(9, f1, t1);
      begin
        wr(`OFS_TXDATA, d1);
        wr(`OFS_STATUS, 8'h7E);
      end
    join
    `CHK("extclk", frame(8'h00, d1, 1'b0, 1'b0, n), f1)
    $display("external clock test done");
    conclude();
  end
endmodule
